// File: rtl/adccal_clkdiv.sv
`timescale 1ns/1ps
module adccal_clkdiv
    import adccal_pkg::*;
#(
    parameter int unsigned DIV = CONVERSION_CLOCK_DIV
) (
    input wire logic clk,
    input wire logic reset,
    output logic tick
);

    logic [15:0] count;
    logic [15:0] next_count;

    always_comb begin
        next_count = count + 16'h0001;
        if (count == 16'(DIV - 1)) begin
            next_count = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count <= 16'h0000;
        end else begin
            count <= next_count;
        end
    end

    assign tick = (count == 16'(DIV - 1));

endmodule

// File: rtl/adccal_offset.sv
`timescale 1ns/1ps
module adccal_offset
    import adccal_pkg::*;
(
    input wire logic [15:0] raw_data,
    input wire logic [15:0] offset,
    input wire logic [1:0] mode,
    input wire logic diff,
    output logic [15:0] corrected
);

    logic [4:0] n;
    logic [4:0] sh;
    logic signed [18:0] raw_s;
    logic signed [18:0] ofs_s;
    logic signed [18:0] sum;
    logic signed [18:0] lo;
    logic signed [18:0] hi;

    // The offset is doubled first so that a 16-bit differential result lines up
    // with bit 15 of the offset; below 16 bits its low bits are then lost, as intended.
    always_comb begin
        n = adccal_bits(mode, diff);
        sh = diff ? 5'(5'h11 - n) : 5'(5'h10 - n);
        raw_s = diff ? signed'({{3{raw_data[15]}}, raw_data}) : signed'({3'h0, raw_data});
        ofs_s = signed'({{2{offset[15]}}, offset, 1'b0}) >>> sh;
        sum = raw_s - ofs_s;
        hi = diff ? (19'sd1 <<< (n - 5'h01)) - 19'sd1 : (19'sd1 <<< n) - 19'sd1;
        lo = diff ? -(19'sd1 <<< (n - 5'h01)) : signed'({3'h0, SE_MIN});
        if (sum > hi) begin
            corrected = hi[15:0];
        end else if (sum < lo) begin
            corrected = lo[15:0];
        end else begin
            corrected = sum[15:0];
        end
    end

endmodule

// File: rtl/adccal_pkg.sv
package adccal_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CLEAR = 8'h08;
    localparam logic [7:0] ADDR_ENABLE = 8'h0c;
    localparam logic [7:0] ADDR_OFFSET = 8'h10;
    localparam logic [7:0] ADDR_PLUS = 8'h14;
    localparam logic [7:0] ADDR_MINUS = 8'h18;
    localparam logic [7:0] ADDR_RESULT = 8'h1c;

    // Conversion resolution select; differential modes below 16 bits carry one more bit.
    localparam logic [1:0] MODE_8 = 2'h0;
    localparam logic [1:0] MODE_12 = 2'h1;
    localparam logic [1:0] MODE_10 = 2'h2;
    localparam logic [1:0] MODE_16 = 2'h3;

    typedef struct packed {
        logic [1:0] mode;
        logic diff;
        logic [1:0] averaging_count_select;
        logic averaging_enable;
        logic cal_request;
        logic hw_trigger_select;
    } adccal_ctrl_t;

    typedef struct packed {
        logic calibrate_failed_flag;
        logic conversion_complete_flag;
    } adccal_flags_t;

    localparam int unsigned CTRL_W = $bits(adccal_ctrl_t);
    localparam int unsigned FLAGS_W = $bits(adccal_flags_t);
    localparam adccal_ctrl_t CTRL_RESET = 8'h00;
    localparam adccal_flags_t FLAGS_RESET = 2'h0;
    localparam logic [15:0] REG16_RESET = 16'h0000;
    localparam logic [15:0] SE_MIN = 16'h0000;
    localparam logic [15:0] DIFF_MIN = 16'h8000;

    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CONVERSION_CLOCK_MAX_HZ = 4_000_000;
    localparam int unsigned CONVERSION_CLOCK_DIV = CLK_HZ / CONVERSION_CLOCK_MAX_HZ;
    localparam int unsigned CAL_CONVERSION_CLOCK_MAX = 14000;
    localparam int unsigned CAL_BUS_CYCLES = 100;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OFFSET,
        ST_PLUS,
        ST_MINUS,
        ST_SETTLE
    } adccal_state_t;

    function automatic logic [4:0] adccal_bits(input logic [1:0] mode, input logic diff);
        logic [4:0] n;
        case (mode)
            MODE_8: n = 5'h08;
            MODE_12: n = 5'h0c;
            MODE_10: n = 5'h0a;
            default: n = 5'h10;
        endcase
        if (diff && mode != MODE_16) begin
            n = n + 5'h01;
        end
        return n;
    endfunction

endpackage

// File: rtl/adccal_top.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module adccal_top
    import adccal_pkg::*;
#(
    parameter int unsigned CAL_CONVERSION_CLOCK_LIMIT = CAL_CONVERSION_CLOCK_MAX,
    parameter int unsigned CONVERSION_CLOCK_DIVIDE = CONVERSION_CLOCK_DIV
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic stop_req,
    input wire logic raw_valid,
    input wire logic [15:0] raw_data,
    output logic cal_active,
    output adccal_state_t cal_phase,
    output logic conv_clk_en,
    output logic irq
);

    adccal_state_t state;
    adccal_state_t next_state;
    adccal_ctrl_t ctrl;
    adccal_ctrl_t next_ctrl;
    adccal_ctrl_t wctrl;
    adccal_flags_t status;
    adccal_flags_t next_status;
    adccal_flags_t enable;
    adccal_flags_t next_enable;
    adccal_flags_t set_f;
    adccal_flags_t clr_f;
    logic [15:0] offset_correction;
    logic [15:0] next_offset;
    logic [15:0] cal_offset;
    logic [15:0] next_cal_offset;
    logic [15:0] plus_side_cal_values;
    logic [15:0] next_plus;
    logic [15:0] minus_side_cal_values;
    logic [15:0] next_minus;
    logic [15:0] result;
    logic [15:0] next_result;
    logic [15:0] conversion_clock_count;
    logic [15:0] next_conversion_clock_count;
    logic [6:0] bus_count;
    logic [6:0] next_bus_count;
    logic [DATA_W-1:0] next_rdata;
    logic [15:0] corrected;
    logic cal_busy;
    logic ctrl_wr;
    logic start;
    logic refuse;
    logic abort;
    logic timeout;
    logic finish_ok;
    logic conv_store;

    //////////////////////////////////////////////////////////////////////////
    adccal_clkdiv #(
        .DIV(CONVERSION_CLOCK_DIVIDE)
    ) u_div (
        .clk(clk),
        .reset(reset),
        .tick(conv_clk_en)
    );

    adccal_offset u_ofs (
        .raw_data(raw_data),
        .offset(offset_correction),
        .mode(ctrl.mode),
        .diff(ctrl.diff),
        .corrected(corrected)
    );

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        wctrl = adccal_ctrl_t'(wdata[CTRL_W-1:0]);
        cal_busy = (state != ST_IDLE);
        ctrl_wr = wr && (addr == ADDR_CTRL);
        start = !cal_busy && ctrl_wr && wctrl.cal_request && !wctrl.hw_trigger_select;
        refuse = !cal_busy && ctrl_wr && wctrl.cal_request && wctrl.hw_trigger_select;
        abort = cal_busy && (wr || stop_req);
        timeout = cal_busy && !abort && conv_clk_en
            && (conversion_clock_count == 16'(CAL_CONVERSION_CLOCK_LIMIT - 1));
        finish_ok = (state == ST_SETTLE) && !abort && !timeout
            && (bus_count == 7'(CAL_BUS_CYCLES - 1));
        // Normal results are dropped while calibrating.
        conv_store = !cal_busy && raw_valid;

        next_state = state;
        next_ctrl = ctrl;
        next_enable = enable;
        next_offset = offset_correction;
        next_cal_offset = cal_offset;
        next_plus = plus_side_cal_values;
        next_minus = minus_side_cal_values;
        next_result = result;
        next_conversion_clock_count = conversion_clock_count;
        next_bus_count = bus_count;
        set_f = FLAGS_RESET;
        clr_f = FLAGS_RESET;

        // Writes that arrive during calibration are discarded, not only aborting.
        if (wr && !cal_busy) begin
            case (addr)
                ADDR_CTRL: begin
                    next_ctrl = wctrl;
                    next_ctrl.cal_request = start;
                end
                ADDR_CLEAR: clr_f = adccal_flags_t'(wdata[FLAGS_W-1:0]);
                ADDR_ENABLE: next_enable = adccal_flags_t'(wdata[FLAGS_W-1:0]);
                ADDR_OFFSET: next_offset = wdata[15:0];
                ADDR_PLUS: next_plus = wdata[15:0];
                ADDR_MINUS: next_minus = wdata[15:0];
                default: ;
            endcase
        end
        if (rd && addr == ADDR_RESULT) begin
            clr_f.conversion_complete_flag = 1'b1;
        end
        if (refuse) begin
            set_f.calibrate_failed_flag = 1'b1;
        end
        if (start) begin
            clr_f.calibrate_failed_flag = 1'b1;
            next_state = ST_OFFSET;
            next_conversion_clock_count = 16'h0000;
        end
        if (conv_store) begin
            next_result = corrected;
            set_f.conversion_complete_flag = 1'b1;
        end

        if (cal_busy) begin
            if (conv_clk_en) begin
                next_conversion_clock_count = conversion_clock_count + 16'h0001;
            end
            case (state)
                ST_OFFSET: begin
                    if (raw_valid) begin
                        next_cal_offset = raw_data;
                        next_state = ST_PLUS;
                    end
                end
                ST_PLUS: begin
                    if (raw_valid) begin
                        next_plus = raw_data;
                        next_state = ST_MINUS;
                    end
                end
                ST_MINUS: begin
                    if (raw_valid) begin
                        next_minus = raw_data;
                        next_state = ST_SETTLE;
                        next_bus_count = 7'h00;
                    end
                end
                ST_SETTLE: next_bus_count = bus_count + 7'h01;
                default: next_state = ST_IDLE;
            endcase
            if (abort || timeout) begin
                next_state = ST_IDLE;
                next_ctrl.cal_request = 1'b0;
                set_f.calibrate_failed_flag = 1'b1;
            end
            // A timeout still ends the sequence, so it reports completion too.
            if (timeout) begin
                set_f.conversion_complete_flag = 1'b1;
            end
            if (finish_ok) begin
                next_state = ST_IDLE;
                next_ctrl.cal_request = 1'b0;
                next_offset = cal_offset;
                set_f.conversion_complete_flag = 1'b1;
            end
        end

        // An event in the same cycle as its clear keeps the flag set.
        next_status = (status & ~clr_f) | set_f;

        case (addr)
            ADDR_CTRL: next_rdata = DATA_W'(ctrl);
            ADDR_STATUS: next_rdata = DATA_W'(status);
            ADDR_ENABLE: next_rdata = DATA_W'(enable);
            ADDR_OFFSET: next_rdata = DATA_W'(offset_correction);
            ADDR_PLUS: next_rdata = DATA_W'(plus_side_cal_values);
            ADDR_MINUS: next_rdata = DATA_W'(minus_side_cal_values);
            ADDR_RESULT: next_rdata = DATA_W'(result);
            default: next_rdata = '0;
        endcase
        if (!rd) begin
            next_rdata = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ST_IDLE;
            ctrl <= CTRL_RESET;
            status <= FLAGS_RESET;
            enable <= FLAGS_RESET;
            offset_correction <= REG16_RESET;
            cal_offset <= REG16_RESET;
            plus_side_cal_values <= REG16_RESET;
            minus_side_cal_values <= REG16_RESET;
            result <= REG16_RESET;
            conversion_clock_count <= 16'h0000;
            bus_count <= 7'h00;
            rdata <= '0;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            status <= next_status;
            enable <= next_enable;
            offset_correction <= next_offset;
            cal_offset <= next_cal_offset;
            plus_side_cal_values <= next_plus;
            minus_side_cal_values <= next_minus;
            result <= next_result;
            conversion_clock_count <= next_conversion_clock_count;
            bus_count <= next_bus_count;
            rdata <= next_rdata;
        end
    end

    assign cal_active = cal_busy;
    assign cal_phase = state;
    assign irq = |(status & enable);

    //////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    chk_cal_start: assert property (start |=> cal_active && ctrl.cal_request)
        else $error("calibration did not start");
    chk_trig_refuse: assert property (refuse |=> !cal_active && !ctrl.cal_request
        && status.calibrate_failed_flag)
        else $error("triggered request not refused");
    chk_abort_fail: assert property (abort |=> !cal_active && !ctrl.cal_request
        && status.calibrate_failed_flag)
        else $error("abort did not fail calibration");
    chk_done_complete: assert property (finish_ok |=> status.conversion_complete_flag
        && (irq == enable.conversion_complete_flag || enable.calibrate_failed_flag))
        else $error("calibration end not flagged");
    chk_success_clean: assert property (finish_ok |=> !status.calibrate_failed_flag)
        else $error("successful calibration shows failure");
    chk_offset_load: assert property (finish_ok |=>
        offset_correction == $past(cal_offset) && !ctrl.cal_request)
        else $error("offset not loaded at calibration end");
    chk_cal_ignore: assert property (cal_busy && raw_valid && !abort |=> $stable(result))
        else $error("result changed during calibration");
    chk_cal_bound: assert property (timeout |=> !cal_active ##1 !cal_active)
        else $error("calibration overran its limit");
    chk_rerun_full: assert property (start |=> state == ST_OFFSET
        && conversion_clock_count <= 16'h0001)
        else $error("rerun did not restart sequence");
    chk_zero_offset: assert property (conv_store && offset_correction == REG16_RESET
        && ctrl.mode == MODE_16 && ctrl.diff |=> result == $past(raw_data))
        else $error("zero offset altered result");
    chk_se_floor: assert property (conv_store && !ctrl.diff
        && raw_data == SE_MIN && !offset_correction[15] |=> result == SE_MIN)
        else $error("single-ended floor missed");
    chk_user_offset: assert property (wr && !cal_busy && addr == ADDR_OFFSET
        |=> offset_correction == $past(wdata[15:0]))
        else $error("offset write lost");
    chk_request_view: assert property (cal_active |-> ctrl.cal_request)
        else $error("request bit clear while calibrating");

    cov_cal_ok: cover property (start ##[1:300] finish_ok);
    cov_cal_abort: cover property (cal_busy ##1 abort);
    cov_refused: cover property (refuse);
    cov_conv: cover property (conv_store && offset_correction != REG16_RESET);

endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import adccal_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic stop_req = 1'b0;
    logic raw_valid = 1'b0;
    logic [15:0] raw_data = 16'h0000;
    logic cal_active;
    adccal_state_t cal_phase;
    logic conv_clk_en;
    logic irq;
    int error_cnt = 0;
    int samples_checked = 0;

    always #12.5 clk = ~clk;

    // A short timeout keeps the run brief; the divider holds the conversion clock at 4 MHz.
    adccal_top #(.CAL_CONVERSION_CLOCK_LIMIT(200), .CONVERSION_CLOCK_DIVIDE(10)) adccal_top_i (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .stop_req(stop_req), .raw_valid(raw_valid), .raw_data(raw_data),
        .cal_active(cal_active), .cal_phase(cal_phase), .conv_clk_en(conv_clk_en), .irq(irq)
    );

    //////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // Read data are only valid in the cycle after the strobe, so sample just after that edge.
    task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(name, exp, rdata);
    endtask

    task automatic sample(input logic [15:0] d);
        @(posedge clk);
        raw_valid <= 1'b1;
        raw_data <= d;
        @(posedge clk);
        raw_valid <= 1'b0;
        raw_data <= ~d;
        #1;
    endtask

    // No clear beforehand: the start itself must drop an old failure.
    task automatic start_cal(input logic [31:0] ctrl);
        wr_reg(ADDR_CTRL, ctrl);
        check("cal_active", 32'h1, {31'h0, cal_active});
        check("phase", {29'h0, ST_OFFSET}, {29'h0, cal_phase});
        rd_check("ctrl busy", ADDR_CTRL, ctrl);
    endtask

    //////////////////////////////////////////////////////////////////////////////
    task automatic reset_values();
        int n;
        n = 0;
        repeat (20) begin
            @(posedge clk);
            #1;
            if (conv_clk_en === 1'b1) begin
                n++;
            end
        end
        check("conv_clk_en", 32'd2, n);
        rd_check("status", ADDR_STATUS, 32'h0);
        rd_check("ctrl", ADDR_CTRL, 32'h0);
        rd_check("offset", ADDR_OFFSET, 32'h0);
        wr_reg(8'h20, 32'hffff_ffff);
        rd_check("unmapped", 8'h20, 32'h0);
        wr_reg(ADDR_OFFSET, 32'hffff_ffff);
        rd_check("offset rw", ADDR_OFFSET, 32'h0000_ffff);
        check("irq idle", 32'h0, {31'h0, irq});
    endtask

    task automatic trigger_refused();
        wr_reg(ADDR_CTRL, 32'h0000_0003);
        check("cal_active", 32'h0, {31'h0, cal_active});
        rd_check("ctrl", ADDR_CTRL, 32'h0000_0001);
        rd_check("status", ADDR_STATUS, 32'h0000_0002);
        wr_reg(ADDR_CTRL, 32'h0);
    endtask

    task automatic full_cal(input logic [31:0] ctrl, input logic [15:0] o, input logic [15:0] p);
        int n;
        start_cal(ctrl);
        sample(o);
        check("phase", {29'h0, ST_PLUS}, {29'h0, cal_phase});
        sample(p);
        check("phase", {29'h0, ST_MINUS}, {29'h0, cal_phase});
        sample(~p);
        check("phase", {29'h0, ST_SETTLE}, {29'h0, cal_phase});
        n = 0;
        while (cal_active === 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("settle", 32'd100, n);
        if (n >= 300) begin
            complete_run();
        end
        rd_check("status", ADDR_STATUS, 32'h0000_0001);
        check("irq", 32'h1, {31'h0, irq});
        rd_check("ctrl", ADDR_CTRL, ctrl & 32'hffff_fffd);
        rd_check("offset", ADDR_OFFSET, {16'h0, o});
        rd_check("plus", ADDR_PLUS, {16'h0, p});
        rd_check("minus", ADDR_MINUS, {16'h0, ~p});
        wr_reg(ADDR_CLEAR, 32'h0000_0001);
        check("irq cleared", 32'h0, {31'h0, irq});
    endtask

    task automatic abort_cal();
        start_cal(32'h0000_0002);
        wr_reg(ADDR_ENABLE, 32'h0000_0000);
        check("cal_active", 32'h0, {31'h0, cal_active});
        rd_check("status", ADDR_STATUS, 32'h0000_0002);
        rd_check("enable kept", ADDR_ENABLE, 32'h0000_0001);
        rd_check("ctrl", ADDR_CTRL, 32'h0);
        start_cal(32'h0000_0002);
        sample(16'h0123);
        @(posedge clk);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
        #1;
        check("cal_active", 32'h0, {31'h0, cal_active});
        rd_check("status", ADDR_STATUS, 32'h0000_0002);
        rd_check("ctrl", ADDR_CTRL, 32'h0);
    endtask

    task automatic timeout_cal();
        int n;
        start_cal(32'h0000_0002);
        n = 0;
        while (cal_active === 1'b1 && n < 2100) begin
            @(posedge clk);
            #1;
            n++;
        end
        // The limit is 200 conversion clocks of 10 cycles each, less the start overhead.
        check("timeout", 32'h1, {31'h0, n > 1980 && n < 2100});
        rd_check("status", ADDR_STATUS, 32'h0000_0003);
        if (n >= 2100) begin
            complete_run();
        end
    endtask

    task automatic corrections();
        logic [7:0] ctl[10] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'he0, 8'hc0, 8'h40, 8'ha0,
                                8'he0, 8'h00};
        logic [15:0] ofs[10] = '{16'h0080, 16'h0800, 16'hff80, 16'h0100, 16'h0001,
                                 16'h0001, 16'h0010, 16'hfc00, 16'h0000, 16'h0080};
        logic [15:0] raw[10] = '{16'h0010, 16'h0005, 16'h00ff, 16'hff00, 16'h8000,
                                 16'h1000, 16'h0100, 16'h03ff, 16'h8001, 16'h0000};
        logic [15:0] exp[10] = '{16'h000f, 16'h0000, 16'h00ff, 16'hff00, 16'h8000,
                                 16'h0ffe, 16'h00fe, 16'h03ff, 16'h8001, 16'h0000};
        wr_reg(ADDR_CLEAR, 32'h0000_0003);
        for (int i = 0; i < 10; i++) begin
            wr_reg(ADDR_OFFSET, {16'h0, ofs[i]});
            wr_reg(ADDR_CTRL, {24'h0, ctl[i]});
            sample(raw[i]);
            check("conv irq", 32'h1, {31'h0, irq});
            rd_check("result", ADDR_RESULT, {16'h0, exp[i]});
            rd_check("status", ADDR_STATUS, 32'h0);
        end
        wr_reg(ADDR_ENABLE, 32'h0);
        sample(16'h0020);
        check("masked irq", 32'h0, {31'h0, irq});
        wr_reg(ADDR_ENABLE, 32'h0000_0001);
        check("unmasked irq", 32'h1, {31'h0, irq});
        wr_reg(ADDR_CLEAR, 32'h0000_0001);
        check("cleared irq", 32'h0, {31'h0, irq});
    endtask

    //////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        reset_values();
        trigger_refused();
        wr_reg(ADDR_ENABLE, 32'h0000_0001);
        full_cal(32'h0000_0002, 16'h0040, 16'h1111);
        full_cal(32'h0000_00fe, 16'hffc0, 16'h2345);
        abort_cal();
        timeout_cal();
        corrections();
        complete_run();
    end
endmodule
